// [verilog/alarm_level_code_encoder.sv]
// Purpose: grades alarms, drives lamp, alarm output, stop and simple code pins
// Assumes: all inputs synchronous to i_mclk; events are one-cycle pulses
// Notes: outputs lag an event by two clock edges, o_warning_active by one
module alarm_level_code_encoder (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_alarm_event,
    input wire logic [11:0] i_alarm_code,
    input wire logic i_pio_alarm_reset,
    input wire logic i_tool_alarm_reset,
    input wire logic i_software_reset,
    input wire logic [2:0] i_mode,
    input wire logic [3:0] i_position_number,
    input wire logic i_motion_stopped,
    input wire logic i_incremental_encoder,
    input wire logic i_home_return_done,
    input wire logic i_option_link_error,
    input wire logic i_cpu_abnormal_reset,
    output logic o_alarm_output,
    output logic o_code_weight_eight_output,
    output logic o_code_weight_four_output,
    output logic o_code_weight_two_output,
    output logic o_code_weight_one_output,
    output logic o_lamp_green,
    output logic o_lamp_red,
    output logic o_decel_stop,
    output logic o_servo_off,
    output logic o_home_required,
    output logic o_warning_active,
    output alarm_pkg::level_t o_alarm_level,
    output logic [3:0] o_simple_code,
    output alarm_pkg::log_entry_t o_log_entry
);
    import alarm_pkg::*;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic alarm_class_t pick_worse(input alarm_class_t a, input alarm_class_t b);
        if (a.level >= b.level) begin
            return a;
        end else begin
            return b;
        end
    endfunction

    function automatic logic shows_code(input logic [2:0] mode);
        return (mode == MODE_SIMPLE_DIRECT) || (mode == MODE_POSITIONER1)
            || (mode == MODE_POSITIONER2) || (mode == MODE_POSITIONER5);
    endfunction

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    alarm_class_t drv_class;
    alarm_class_t drv_cand;
    alarm_class_t cpu_cand;
    alarm_class_t link_cand;
    alarm_class_t incoming;
    logic take;
    logic alarm_reset;
    logic active;
    logic message_seen;
    logic cold_cleared;
    level_t held_level_reg;
    logic [3:0] held_code_reg;
    logic warning_reg;
    logic home_required_reg;
    stop_state_t state_reg;
    logic alarm_out_reg;
    logic lamp_red_reg;
    logic lamp_green_reg;
    level_t level_out_reg;
    logic [3:0] code_out_reg;
    logic [3:0] pins_reg;

    // ------------------------------------------------------------
    // classification and arbitration
    // ------------------------------------------------------------
    alarm_code_classifier u_classifier (
        .i_code(i_alarm_code),
        .o_class(drv_class)
    );

    gateway_alarm_log u_log (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_option_link_error(i_option_link_error),
        .i_cpu_abnormal_reset(i_cpu_abnormal_reset),
        .o_entry(o_log_entry)
    );

    always_comb begin
        drv_cand = i_alarm_event ? drv_class : '{level: LEVEL_NONE, code: SIMPLE_NONE};
        // gateway alarms enter grading
        cpu_cand = i_cpu_abnormal_reset ? '{level: GW_CPU_LEVEL, code: SIMPLE_NONE}
                                        : '{level: LEVEL_NONE, code: SIMPLE_NONE};
        link_cand = i_option_link_error ? '{level: GW_LINK_LEVEL, code: SIMPLE_NONE}
                                        : '{level: LEVEL_NONE, code: SIMPLE_NONE};
        // most severe wins, first of equal kept
        incoming = pick_worse(pick_worse(cpu_cand, drv_cand), link_cand);
    end

    assign take = (incoming.level > held_level_reg) && (incoming.level >= LEVEL_CANCEL);
    assign alarm_reset = i_pio_alarm_reset | i_tool_alarm_reset;
    assign active = held_level_reg >= LEVEL_CANCEL;
    assign message_seen = drv_cand.level == LEVEL_MESSAGE;
    assign cold_cleared = i_software_reset && (held_level_reg == LEVEL_COLD) && !take;

    // ------------------------------------------------------------
    // held alarm, set wins over clear
    // ------------------------------------------------------------
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            held_level_reg <= LEVEL_NONE;
            held_code_reg <= SIMPLE_NONE;
        end else if (take) begin
            held_level_reg <= incoming.level;
            held_code_reg <= incoming.code;
        end else if (i_software_reset) begin
            held_level_reg <= LEVEL_NONE;
            held_code_reg <= SIMPLE_NONE;
        end else if (alarm_reset && held_level_reg == LEVEL_CANCEL) begin
            held_level_reg <= LEVEL_NONE;
            held_code_reg <= SIMPLE_NONE;
        end
    end

    // ------------------------------------------------------------
    // message-level warning
    // ------------------------------------------------------------
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            warning_reg <= 1'b0;
        end else if (message_seen) begin
            warning_reg <= 1'b1;
        end else if (alarm_reset || i_software_reset) begin
            warning_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // home return demand
    // ------------------------------------------------------------
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            home_required_reg <= 1'b0;
        end else if (cold_cleared && i_incremental_encoder) begin
            home_required_reg <= 1'b1;
        end else if (i_home_return_done) begin
            home_required_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // stop sequence
    // ------------------------------------------------------------
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            state_reg <= STOP_RUN;
        end else begin
            case (state_reg)
                STOP_RUN: begin
                    if (active) begin
                        state_reg <= STOP_DECEL;
                    end
                end
                STOP_DECEL: begin
                    if (i_motion_stopped) begin
                        state_reg <= STOP_SERVO_OFF;
                    end
                end
                STOP_SERVO_OFF: begin
                    if (!active) begin
                        state_reg <= STOP_RUN;
                    end
                end
                default: begin
                    state_reg <= STOP_RUN;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // output registers
    // ------------------------------------------------------------
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            alarm_out_reg <= 1'b0;
            lamp_red_reg <= 1'b0;
            lamp_green_reg <= 1'b0;
            level_out_reg <= LEVEL_NONE;
            code_out_reg <= SIMPLE_NONE;
        end else begin
            alarm_out_reg <= active;
            lamp_red_reg <= active;
            lamp_green_reg <= !active;
            level_out_reg <= warning_reg && !active ? LEVEL_MESSAGE : held_level_reg;
            code_out_reg <= active ? held_code_reg : SIMPLE_NONE;
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            pins_reg <= PINS_RESET;
        end else if (active && shows_code(i_mode)) begin
            pins_reg <= held_code_reg;
        end else begin
            pins_reg <= i_position_number;
        end
    end

    assign o_alarm_output = alarm_out_reg;
    assign o_code_weight_eight_output = pins_reg[3];
    assign o_code_weight_four_output = pins_reg[2];
    assign o_code_weight_two_output = pins_reg[1];
    assign o_code_weight_one_output = pins_reg[0];
    assign o_lamp_green = lamp_green_reg;
    assign o_lamp_red = lamp_red_reg;
    assign o_decel_stop = state_reg == STOP_DECEL;
    assign o_servo_off = state_reg == STOP_SERVO_OFF;
    assign o_home_required = home_required_reg;
    assign o_warning_active = warning_reg;
    assign o_alarm_level = level_out_reg;
    assign o_simple_code = code_out_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_message_keeps_green: assert property (@(posedge i_mclk) disable iff (i_rst)
        message_seen && held_level_reg == LEVEL_NONE && !take
        |=> o_warning_active ##1 (!o_alarm_output && o_lamp_green))
        else $error("message alarm disturbed lamp or alarm output");

    a_warning_reset_clear: assert property (@(posedge i_mclk) disable iff (i_rst)
        alarm_reset && !message_seen |=> !o_warning_active)
        else $error("alarm reset left warning set");

    a_cancel_raises_alarm: assert property (@(posedge i_mclk) disable iff (i_rst)
        take && incoming.level == LEVEL_CANCEL |=> ##1 (o_alarm_output && o_lamp_red && !o_lamp_green))
        else $error("cancel alarm not shown");

    a_decel_before_off: assert property (@(posedge i_mclk) disable iff (i_rst)
        (state_reg == STOP_RUN && active) || (o_decel_stop && !i_motion_stopped) |=> o_decel_stop)
        else $error("stop sequence skipped deceleration");

    a_cold_needs_soft: assert property (@(posedge i_mclk) disable iff (i_rst)
        held_level_reg == LEVEL_COLD && !i_software_reset |=> held_level_reg == LEVEL_COLD)
        else $error("cold alarm cleared without software reset");

    a_home_after_cold: assert property (@(posedge i_mclk) disable iff (i_rst)
        cold_cleared && i_incremental_encoder |=> o_home_required)
        else $error("home return not demanded");

    a_code_on_pins: assert property (@(posedge i_mclk) disable iff (i_rst)
        active && shows_code(i_mode)
        |=> {o_code_weight_eight_output, o_code_weight_four_output,
             o_code_weight_two_output, o_code_weight_one_output} == $past(held_code_reg))
        else $error("simple code not on completion pins");

    a_code_needs_alarm: assert property (@(posedge i_mclk) disable iff (i_rst)
        o_simple_code != SIMPLE_NONE |-> o_alarm_output)
        else $error("nonzero code without alarm output");

    a_collision_code: assert property (@(posedge i_mclk) disable iff (i_rst)
        i_alarm_event && i_alarm_code == 12'h0df && held_level_reg == LEVEL_NONE
        |=> ##1 o_simple_code == SIMPLE_COLLISION)
        else $error("collision not coded as 1");

    a_hold_until_reset: assert property (@(posedge i_mclk) disable iff (i_rst)
        active && !alarm_reset && !i_software_reset
        |=> held_level_reg >= $past(held_level_reg) && active)
        else $error("alarm dropped without reset");

    a_severe_kept: assert property (@(posedge i_mclk) disable iff (i_rst)
        held_level_reg == LEVEL_COLD && !i_software_reset
        |=> $stable(held_code_reg))
        else $error("less severe alarm replaced code");

    a_cold_raises_alarm: assert property (@(posedge i_mclk) disable iff (i_rst)
        take && incoming.level == LEVEL_COLD |=> ##1 (o_alarm_output && o_lamp_red && !o_lamp_green))
        else $error("cold alarm not shown");

    a_soft_clears_cold: assert property (@(posedge i_mclk) disable iff (i_rst)
        held_level_reg == LEVEL_COLD && i_software_reset |=> held_level_reg == LEVEL_NONE)
        else $error("software reset left cold alarm");

    a_servo_after_stop: assert property (@(posedge i_mclk) disable iff (i_rst)
        o_decel_stop && i_motion_stopped |=> o_servo_off)
        else $error("servo not turned off after stop");

    a_servo_held_off: assert property (@(posedge i_mclk) disable iff (i_rst)
        o_servo_off && active |=> o_servo_off)
        else $error("servo released while alarm held");

    a_cancel_reset_clears: assert property (@(posedge i_mclk) disable iff (i_rst)
        held_level_reg == LEVEL_CANCEL && alarm_reset && !take |=> held_level_reg == LEVEL_NONE)
        else $error("alarm reset left cancel alarm");

    a_home_cleared: assert property (@(posedge i_mclk) disable iff (i_rst)
        o_home_required && i_home_return_done && !cold_cleared |=> !o_home_required)
        else $error("home demand kept after home return");

    a_pins_show_position: assert property (@(posedge i_mclk) disable iff (i_rst)
        !(active && shows_code(i_mode))
        |=> {o_code_weight_eight_output, o_code_weight_four_output,
             o_code_weight_two_output, o_code_weight_one_output} == $past(i_position_number))
        else $error("position number not on completion pins");

    a_idle_no_alarm: assert property (@(posedge i_mclk) disable iff (i_rst)
        !active |=> !o_alarm_output && o_simple_code == SIMPLE_NONE && o_lamp_green)
        else $error("alarm shown with nothing held");

    a_level_reported: assert property (@(posedge i_mclk) disable iff (i_rst)
        active |=> o_alarm_level == $past(held_level_reg))
        else $error("held level not reported");

    a_code_reported: assert property (@(posedge i_mclk) disable iff (i_rst)
        active |=> o_simple_code == $past(held_code_reg))
        else $error("held code not reported");

endmodule

// [inc/alarm_pkg.sv]
// Purpose: shared types and constants for the alarm level and code encoder
// Assumes: one clock, asynchronous active-high reset
// Notes: driver alarm codes are 12-bit, three hex digits
package alarm_pkg;

    // ------------------------------------------------------------
    // severity levels and stop sequence
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        LEVEL_NONE = 2'h0,
        LEVEL_MESSAGE = 2'h1,
        LEVEL_CANCEL = 2'h2,
        LEVEL_COLD = 2'h3
    } level_t;

    typedef enum logic [2:0] {
        STOP_RUN = 3'h1,
        STOP_DECEL = 3'h2,
        STOP_SERVO_OFF = 3'h4
    } stop_state_t;

    typedef struct packed {
        level_t level;
        logic [3:0] code;
    } alarm_class_t;

    typedef struct packed {
        logic write;
        logic [11:0] code;
    } log_entry_t;

    // ------------------------------------------------------------
    // simple alarm codes
    // ------------------------------------------------------------
    localparam logic [3:0] SIMPLE_NONE = 4'h0;
    localparam logic [3:0] SIMPLE_COLLISION = 4'h1;
    localparam logic [3:0] SIMPLE_SEQUENCE = 4'h2;
    localparam logic [3:0] SIMPLE_TRAVEL = 4'h3;
    localparam logic [3:0] SIMPLE_HARDWARE = 4'h4;
    localparam logic [3:0] SIMPLE_COMMS = 4'h5;
    localparam logic [3:0] SIMPLE_DATA = 4'h6;
    localparam logic [3:0] SIMPLE_HOMING = 4'h7;
    localparam logic [3:0] SIMPLE_SPEED = 4'h8;
    localparam logic [3:0] SIMPLE_POWER = 4'h9;

    // ------------------------------------------------------------
    // level bands of driver alarm codes
    // ------------------------------------------------------------
    localparam logic [11:0] MESSAGE_FIRST = 12'h040;
    localparam logic [11:0] MESSAGE_LAST = 12'h07f;
    localparam logic [11:0] CANCEL_LAST = 12'h0bf;
    localparam logic [11:0] COLD_LAST = 12'h0ff;

    // ------------------------------------------------------------
    // gateway alarm codes and levels
    // ------------------------------------------------------------
    localparam logic [11:0] GW_OPTION_LINK_CODE = 12'h8df;
    localparam logic [11:0] GW_CPU_RESET_CODE = 12'h8fa;
    localparam logic [11:0] GW_POWER_ON_CODE = 12'hfff;
    localparam level_t GW_LINK_LEVEL = LEVEL_CANCEL;
    localparam level_t GW_CPU_LEVEL = LEVEL_COLD;

    // ------------------------------------------------------------
    // operation modes
    // ------------------------------------------------------------
    localparam logic [2:0] MODE_SIMPLE_DIRECT = 3'h0;
    localparam logic [2:0] MODE_POSITIONER1 = 3'h1;
    localparam logic [2:0] MODE_POSITIONER2 = 3'h2;
    localparam logic [2:0] MODE_POSITIONER3 = 3'h3;
    localparam logic [2:0] MODE_DIRECT_NUMERIC = 3'h4;
    localparam logic [2:0] MODE_POSITIONER5 = 3'h5;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [3:0] PINS_RESET = 4'h0;
    localparam logic POWER_ON_PENDING_RESET = 1'b1;

endpackage

// [verilog/alarm_code_classifier.sv]
// Purpose: grades a driver alarm code and finds its simple code
// Assumes: code is stable while it is read
// Notes: purely combinational
module alarm_code_classifier (
    input wire logic [11:0] i_code,
    output alarm_pkg::alarm_class_t o_class
);
    import alarm_pkg::*;

    // ------------------------------------------------------------
    // severity band
    // ------------------------------------------------------------
    function automatic level_t level_of(input logic [11:0] code);
        if (code >= MESSAGE_FIRST && code <= MESSAGE_LAST) begin
            return LEVEL_MESSAGE;
        end else if (code > MESSAGE_LAST && code <= CANCEL_LAST) begin
            return LEVEL_CANCEL;
        end else if (code > CANCEL_LAST && code <= COLD_LAST) begin
            return LEVEL_COLD;
        end else begin
            return LEVEL_CANCEL;
        end
    endfunction

    // ------------------------------------------------------------
    // simple code table
    // ------------------------------------------------------------
    function automatic logic [3:0] simple_of(input logic [11:0] code);
        case (code)
            12'h0df: return SIMPLE_COLLISION;
            12'h090, 12'h091, 12'h092, 12'h093, 12'h09c: return SIMPLE_SEQUENCE;
            12'h080, 12'h082, 12'h083, 12'h084, 12'h085, 12'h0a3, 12'h0a7: return SIMPLE_TRAVEL;
            12'h0d6, 12'h0f4: return SIMPLE_HARDWARE;
            12'h09b, 12'h09f: return SIMPLE_COMMS;
            12'h0a1, 12'h0a2, 12'h0a8: return SIMPLE_DATA;
            12'h0b5, 12'h0b6, 12'h0b7, 12'h0b8, 12'h0ba, 12'h0be, 12'h0bf: return SIMPLE_HOMING;
            12'h0c0, 12'h0c2: return SIMPLE_SPEED;
            12'h0c8, 12'h0c9, 12'h0ca, 12'h0cb, 12'h0cc, 12'h0cd, 12'h0ce, 12'h0d4: return SIMPLE_POWER;
            default: return SIMPLE_NONE;
        endcase
    endfunction

    // grade then code
    assign o_class = '{level: level_of(i_code), code: simple_of(i_code)};

endmodule

// [verilog/gateway_alarm_log.sv]
// Purpose: gateway alarm log writer
// Assumes: events are one-cycle pulses
// Notes: one entry per cycle, power-on first, then cpu, then link
module gateway_alarm_log (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_option_link_error,
    input wire logic i_cpu_abnormal_reset,
    output alarm_pkg::log_entry_t o_entry
);
    import alarm_pkg::*;

    logic power_on_reg;
    logic cpu_reg;
    logic link_reg;
    log_entry_t entry_reg;

    // ------------------------------------------------------------
    // pending entries, a new event wins over the issue
    // ------------------------------------------------------------
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            power_on_reg <= POWER_ON_PENDING_RESET;
            cpu_reg <= 1'b0;
            link_reg <= 1'b0;
            entry_reg <= '0;
        end else begin
            entry_reg.write <= power_on_reg | cpu_reg | link_reg;
            if (power_on_reg) begin
                entry_reg.code <= GW_POWER_ON_CODE;
                power_on_reg <= 1'b0;
                cpu_reg <= cpu_reg | i_cpu_abnormal_reset;
                link_reg <= link_reg | i_option_link_error;
            end else if (cpu_reg) begin
                entry_reg.code <= GW_CPU_RESET_CODE;
                cpu_reg <= i_cpu_abnormal_reset;
                link_reg <= link_reg | i_option_link_error;
            end else if (link_reg) begin
                entry_reg.code <= GW_OPTION_LINK_CODE;
                cpu_reg <= i_cpu_abnormal_reset;
                link_reg <= i_option_link_error;
            end else begin
                cpu_reg <= i_cpu_abnormal_reset;
                link_reg <= i_option_link_error;
            end
        end
    end

    assign o_entry = entry_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_power_on_entry: assert property (@(posedge i_mclk) disable iff (i_rst)
        $past(i_rst) |=> (o_entry.write && o_entry.code == GW_POWER_ON_CODE))
        else $error("power-on log entry missing");

    a_cpu_entry_logged: assert property (@(posedge i_mclk) disable iff (i_rst)
        i_cpu_abnormal_reset |-> ##[1:3] (o_entry.write && o_entry.code == GW_CPU_RESET_CODE))
        else $error("cpu reset entry not logged");

    a_link_entry_logged: assert property (@(posedge i_mclk) disable iff (i_rst)
        i_option_link_error && !i_cpu_abnormal_reset && !cpu_reg
        |-> ##[1:3] (o_entry.write && o_entry.code == GW_OPTION_LINK_CODE))
        else $error("option link entry not logged");

endmodule

// [dv/alarm_host_model.sv]
// Purpose: host reading alarm pins, plus axis stop response
// Assumes: samples on the rising edge of i_mclk
// Notes: flags each new alarm word seen while alarm output is on
module alarm_host_model (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_alarm,
    input wire logic [3:0] i_pins,
    input wire logic [1:0] i_level,
    input wire logic i_decel,
    output logic o_stopped,
    output logic o_seen_valid,
    output logic [6:0] o_seen
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [6:0] prev_reg;
    logic [1:0] cnt_reg;
    assign o_seen = {i_alarm, i_pins, i_level};
    assign o_seen_valid = i_alarm && (o_seen != prev_reg);
    assign o_stopped = (cnt_reg == 2'h2);
    // axis at rest two cycles into deceleration
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            prev_reg <= 7'h0;
            cnt_reg <= 2'h0;
        end else begin
            prev_reg <= o_seen;
            cnt_reg <= !i_decel ? 2'h0 : (o_stopped ? cnt_reg : cnt_reg + 2'h1);
        end
    end
endmodule

// [dv/alarm_level_code_encoder_test.sv]
// Purpose: self-checking bench of the alarm level and code encoder
// Assumes: inputs change 1 ns after the rising edge
// Notes: driver queues expected words, monitor pops them
module alarm_level_code_encoder_test;
    timeunit 1ns;
    timeprecision 100ps;
    import alarm_pkg::*;
    logic i_mclk = 0, i_rst = 1, evt = 0, pio_rst = 0, tool_rst = 0, sw_rst = 0, home_done = 0, link_err = 0;
    logic cpu_err = 0, cold = 0, stopped, seen_valid, alarm, w8, w4, w2, w1, red, green, decel, servo_off;
    logic home_req, warn, incr = 1;
    logic [11:0] code = 12'h0;
    logic [2:0] mode = 3'h0;
    logic [3:0] pos = 4'h0, simple;
    level_t level;
    log_entry_t log_e;
    logic [6:0] seen, q_alarm[$];
    logic [12:0] q_log[$];
    int n_mismatch = 0, checks = 0, cyc = 0;
    logic [31:0] lfsr = 32'h7f355336;
    logic [11:0] codes[9] = '{12'h0df, 12'h090, 12'h080, 12'h0d6, 12'h09b, 12'h0a1, 12'h0b5, 12'h0c0, 12'h0c8};
    alarm_level_code_encoder u_alarm_level_code_encoder (.i_mclk(i_mclk), .i_rst(i_rst), .i_alarm_event(evt),
        .i_alarm_code(code), .i_pio_alarm_reset(pio_rst), .i_tool_alarm_reset(tool_rst), .i_software_reset(sw_rst),
        .i_mode(mode), .i_position_number(pos), .i_motion_stopped(stopped), .i_incremental_encoder(incr),
        .i_home_return_done(home_done), .i_option_link_error(link_err), .i_cpu_abnormal_reset(cpu_err),
        .o_alarm_output(alarm), .o_code_weight_eight_output(w8), .o_code_weight_four_output(w4),
        .o_code_weight_two_output(w2), .o_code_weight_one_output(w1), .o_lamp_green(green), .o_lamp_red(red),
        .o_decel_stop(decel), .o_servo_off(servo_off), .o_home_required(home_req), .o_warning_active(warn),
        .o_alarm_level(level), .o_simple_code(simple), .o_log_entry(log_e));
    alarm_host_model u_alarm_host_model (.i_mclk(i_mclk), .i_rst(i_rst), .i_alarm(alarm),
        .i_pins({w8, w4, w2, w1}), .i_level(level), .i_decel(decel), .o_stopped(stopped),
        .o_seen_valid(seen_valid), .o_seen(seen));
    initial begin
        forever #5 i_mclk = ~i_mclk;
    end
    task automatic step(input int n);
        repeat (n) begin
            @(posedge i_mclk);
            #1;
        end
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        step(1);
        s = 1'b0;
    endtask
    task automatic cmp(input logic [12:0] got, input logic [12:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_alarm(input logic [6:0] got, input logic [6:0] exp);
        cmp({6'h0, got}, {6'h0, exp});
    endtask
    task automatic cmp_log(input logic [12:0] got, input logic [12:0] exp);
        cmp(got, exp);
    endtask
    task automatic cmp_flag(input logic got, input logic exp);
        cmp({12'h0, got}, {12'h0, exp});
    endtask
    task automatic cmp_code(input logic [3:0] got, input logic [3:0] exp);
        cmp({9'h0, got}, {9'h0, exp});
    endtask
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic fire(input logic [11:0] c, input logic [6:0] e);
        q_alarm.push_back(e);
        code = c;
        pulse(evt);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    always @(negedge i_mclk) begin
        if (seen_valid === 1'b1) begin
            cmp_alarm(seen, q_alarm.size() > 0 ? q_alarm.pop_front() : 7'h7f);
        end
        if (log_e.write === 1'b1) begin
            cmp_log(log_e, q_log.size() > 0 ? q_log.pop_front() : 13'h0);
        end
        cyc++;
        if (cyc > 3000) begin
            n_mismatch++;
            conclude();
        end
    end
    initial begin
        q_log.push_back({1'b1, 12'hfff});
        step(5);
        i_rst = 0;
        step(3);
        cmp_flag(green, 1'b1);
        for (int i = 0; i < 9; i++) begin
            lfsr = lfsr_next(lfsr);
            pos = lfsr[3:0];
            mode = 3'(i % 6);
            incr = i[0];
            cold = codes[i] >= 12'h0c0;
            fire(codes[i], {1'b1, mode inside {3'h0, 3'h1, 3'h2, 3'h5} ? 4'(i + 1) : pos, cold ? 2'h3 : 2'h2});
            step(3);
            cmp_flag(red && decel, 1'b1);
            cmp_code(simple, 4'(i + 1));
            step(4);
            cmp_flag(servo_off, 1'b1);
            if (i[0]) pulse(tool_rst);
            else pulse(pio_rst);
            step(2);
            cmp_flag(alarm, cold);
            pulse(sw_rst);
            step(2);
            cmp_flag(home_req, cold && incr);
            pulse(home_done);
            step(2);
            cmp_flag(home_req || alarm, 1'b0);
        end
        $display("test simple codes done");
        mode = 3'h0;
        fire(12'h090, {1'b1, 4'h2, 2'h2});
        step(2);
        fire(12'h0c8, {1'b1, 4'h9, 2'h3});
        code = 12'h080;
        step(2);
        pulse(evt);
        step(3);
        cmp_code(simple, 4'h9);
        pulse(sw_rst);
        pulse(home_done);
        $display("test severity done");
        code = 12'h048;
        pulse(evt);
        step(2);
        cmp_flag(warn && green && !alarm, 1'b1);
        pulse(pio_rst);
        step(2);
        cmp_flag(warn, 1'b0);
        $display("test message done");
        q_log.push_back({1'b1, 12'h8df});
        q_alarm.push_back({1'b1, 4'h0, 2'h2});
        pulse(link_err);
        step(4);
        pulse(pio_rst);
        q_log.push_back({1'b1, 12'h8fa});
        q_alarm.push_back({1'b1, 4'h0, 2'h3});
        pulse(cpu_err);
        step(4);
        pulse(sw_rst);
        step(2);
        cmp_flag(q_alarm.size() == 0 && q_log.size() == 0, 1'b1);
        $display("test gateway done");
        conclude();
    end
endmodule
